// ### hw/cbu_branch_unit.v
// Conditional relative branch unit: condition test, timing and PC update.
// Operation
// - Carry set branch taken when carry is one.
// - Carry clear branch taken when carry is zero.
// - Unsigned same-or-higher equals carry clear branch.
// - Unsigned lower equals carry set branch.
// - Negative branch taken when negative flag one.
// - Positive branch taken when negative flag zero.
// - Signed ge taken when N xor V zero.
// - Signed lt taken when N xor V one.
// - Taken target is PC plus offset plus one.
// - No flag change; one or two cycles.
`include "cbu_defines.vh"

module cbu_branch_unit (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Instruction issue
  input wire issue_i,
  input wire [`CBU_OP_W-1:0] op_i,
  input wire [`CBU_OFS_W-1:0] offset_i,
  // Status flags from the core
  input wire carry_i,
  input wire negative_i,
  input wire overflow_i,
  // Program counter and status
  output reg [`CBU_PC_W-1:0] pc_o,
  output reg busy_o,
  output reg done_o,
  output reg taken_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_TAKEN = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`CBU_PC_W-1:0] target_q;
  wire cond_taken;
  wire [`CBU_PC_W-1:0] ofs_ext;
  wire [`CBU_PC_W-1:0] target_d;
  wire [`CBU_PC_W-1:0] next_seq;

  cbu_cond_eval u_eval (
    .op_i(op_i),
    .carry_i(carry_i),
    .negative_i(negative_i),
    .overflow_i(overflow_i),
    .taken_o(cond_taken)
  );

  // The offset is a signed word displacement, so sign-extend it.
  assign ofs_ext = {{(`CBU_PC_W-`CBU_OFS_W){offset_i[`CBU_OFS_W-1]}},
                    offset_i};
  assign next_seq = pc_o + `CBU_PC_STEP;
  assign target_d = next_seq + ofs_ext;

  always @* begin
    case (state_q)
      ST_IDLE: begin
        if (issue_i && cond_taken) begin
          state_d = ST_TAKEN;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_TAKEN: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Flags are inputs only; nothing here writes the status register.
  // A taken branch occupies a second cycle to load the target, which is
  // why issue is ignored while busy.
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
      pc_o <= `CBU_PC_RST;
      target_q <= `CBU_PC_RST;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      taken_o <= 1'b0;
    end else begin
      state_q <= state_d;
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (issue_i) begin
            taken_o <= cond_taken;
            if (cond_taken) begin
              target_q <= target_d;
              busy_o <= 1'b1;
            end else begin
              pc_o <= next_seq;
              done_o <= 1'b1;
            end
          end
        end
        ST_TAKEN: begin
          pc_o <= target_q;
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        default: begin
          busy_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### common/cbu_defines.vh
// Constants for the conditional branch unit.
`ifndef CBU_DEFINES_VH
`define CBU_DEFINES_VH
`define CBU_PC_W 16
`define CBU_OFS_W 7
`define CBU_OP_W 3
`define CBU_OP_CARRY_SET 3'h0
`define CBU_OP_CARRY_CLEAR 3'h1
`define CBU_OP_UNSIGNED_GE 3'h2
`define CBU_OP_UNSIGNED_LT 3'h3
`define CBU_OP_NEGATIVE 3'h4
`define CBU_OP_POSITIVE 3'h5
`define CBU_OP_SIGNED_GE 3'h6
`define CBU_OP_SIGNED_LT 3'h7
`define CBU_PC_RST 16'h0000
`define CBU_PC_STEP 16'h0001
`define CBU_TAKEN_CYCLES 2
`define CBU_NOT_TAKEN_CYCLES 1
`endif

// ### hw/cbu_cond_eval.v
// Combinational condition test for the flag-testing branch group.
`include "cbu_defines.vh"

module cbu_cond_eval (
  // Operation and flags
  input wire [`CBU_OP_W-1:0] op_i,
  input wire carry_i,
  input wire negative_i,
  input wire overflow_i,
  // Decision
  output reg taken_o
);

  always @* begin
    case (op_i)
      `CBU_OP_CARRY_SET: taken_o = carry_i;
      `CBU_OP_CARRY_CLEAR: taken_o = ~carry_i;
      `CBU_OP_UNSIGNED_GE: taken_o = ~carry_i;
      `CBU_OP_UNSIGNED_LT: taken_o = carry_i;
      `CBU_OP_NEGATIVE: taken_o = negative_i;
      `CBU_OP_POSITIVE: taken_o = ~negative_i;
      `CBU_OP_SIGNED_GE: taken_o = ~(negative_i ^ overflow_i);
      `CBU_OP_SIGNED_LT: taken_o = negative_i ^ overflow_i;
      default: taken_o = 1'b0;
    endcase
  end

endmodule

// ### verification/cbu_branch_unit_properties.sv
// Port assertions for the branch unit.
module cbu_chk (
  input wire clk_i, srst_i, issue_i, carry_i, negative_i, overflow_i,
  input wire [2:0] op_i,
  input wire [6:0] offset_i,
  input wire [15:0] pc_o,
  input wire busy_o, done_o, taken_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire x = negative_i ^ overflow_i;
  wire [7:0] m = {x, ~x, ~negative_i, negative_i, carry_i, ~carry_i,
    ~carry_i, carry_i};
  wire go = issue_i & ~busy_o;
  wire t = m[op_i];
  wire [15:0] tg = pc_o + {{9{offset_i[6]}}, offset_i} + 16'h1;
  sequence s_tk; go && t ##1 busy_o; endsequence
  property p_dec; go |=> taken_o == $past(t); endproperty
  property p_tk; go && t |=> busy_o && !done_o; endproperty
  property p_tg; s_tk |=> done_o && pc_o == $past(tg, 2); endproperty
  property p_nt; go && !t |=> done_o && pc_o == $past(pc_o) + 16'h1;
  endproperty
  property p_bz; busy_o |-> $past(go && t); endproperty
  property p_ig; busy_o |=> !busy_o; endproperty
  property p_dn; done_o |-> $past(busy_o || go && !t); endproperty
  property p_hd; !go |=> $stable(taken_o); endproperty
  a_dec: assert property(p_dec) else $error("dec");
  a_tk: assert property(p_tk) else $error("tk");
  a_tg: assert property(p_tg) else $error("tg");
  a_nt: assert property(p_nt) else $error("nt");
  a_bz: assert property(p_bz) else $error("bz");
  a_ig: assert property(p_ig) else $error("ig");
  a_dn: assert property(p_dn) else $error("dn");
  a_hd: assert property(p_hd) else $error("hd");
endmodule
bind cbu_branch_unit cbu_chk u_chk (.*);

// ### verification/conditional_branch_unit_test.sv
// Bench for the branch unit.
module conditional_branch_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, srst_i = 1, issue_i = 0, carry_i = 0, e;
  logic negative_i = 0, overflow_i = 0;
  logic [2:0] op_i = 0;
  logic [6:0] offset_i = 0;
  logic [15:0] p = 0;
  wire [15:0] pc_o;
  wire busy_o, done_o, taken_o;
  int error_cnt = 0, samples_checked = 0;
  // Taken mask per operation, indexed by the flags {N, V, C}.
  logic [7:0] tbl [8] = '{8'hAA, 8'h55, 8'h55, 8'hAA, 8'hF0, 8'h0F,
    8'hC3, 8'h3C};
  cbu_branch_unit uut (.*);
  always #50 clk_i = ~clk_i;
  task chk(input logic [17:0] g, w);
    samples_checked++;
    if (g !== w) begin
      error_cnt++;
      $display("unexpected at %0t: %h %h", $time, g, w);
    end
  endtask
  task final_report(input int n);
    error_cnt += n;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial #20000 final_report(1);
  // Issue stays high, so the busy cycle also shows that requests are ignored.
  initial begin
    repeat (4) @(negedge clk_i);
    chk(pc_o, 0);
    srst_i = 0;
    for (int i = 0; i < 64; i++) begin
      {op_i, negative_i, overflow_i, carry_i} = i[5:0];
      offset_i = {i[2:0], i[5:2]};
      issue_i = 1;
      e = tbl[op_i][i[2:0]];
      @(negedge clk_i);
      if (e) begin
        chk(busy_o, 1);
        @(negedge clk_i);
      end
      p = p + 16'h1 + (e ? {{9{offset_i[6]}}, offset_i} : 16'h0);
      chk({done_o, taken_o, pc_o}, {1'h1, e, p});
    end
    final_report(0);
  end
endmodule
